// File: rtl/jdr_data_regs.sv
// Boundary-scan data registers: bypass, identification and boundary
// scan register, with pad and termination control and a Wishbone slave.
// Assumes an outside TAP controller decodes its states on tck and that
// tck stops only between scans; the core drives func_out on clock.
//
// Overview of operation
// - Bypass cell captures zero at capture
// - Bypass cell alone between tdi and tdo
// - Identification code loaded, then shifted out
// - Identification word: part, maker, start bit one
// - Identification shifts into msb, lsb out
// - Boundary register captures ring in scan modes
// - Boundary register in path for scan modes
// - External test drives pins after update only
// - Unused pins capture level, unconnected capture zero
// - Top internal cell always captures one
// - Internal cell gates data drivers in external test
// - Termination off in external test, high-Z sample
// - Cell one leaves first, tdi enters top
// - Cells map to pads, top is internal
// - Sample tdi rising, drive tdo falling
// - Three-bit instruction codes decoded as listed
// - Identification instruction active after reset
`timescale 1ns/1ps
`include "jdr_params.svh"

module jdr_data_regs (
  // System clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`JDR_WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Test clock side
  input  wire logic                    tck,
  input  wire logic                    tap_rst_n,
  input  wire jdr_pkg::jdr_tap_s       tap,
  output logic                         tdo,
  output logic                         tdo_oe,
  // Pad ring
  input  wire logic [`JDR_PAD_N-1:0]   pad_in,
  input  wire logic [`JDR_PAD_N-1:0]   func_out,
  output logic      [`JDR_PAD_N-1:0]   pad_out,
  output logic      [`JDR_PAD_N-1:0]   pad_oe,
  output logic                         odt_en
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  jdr_pkg::jdr_tck_s t_q;              // Test clock state
  jdr_pkg::jdr_tck_s t_d;              // Its next value
  jdr_pkg::jdr_clk_s c_q;              // System clock state
  jdr_pkg::jdr_clk_s c_d;              // Its next value
  logic              tdo_q;            // Falling-edge output flop
  logic              tdo_oe_q;         // Falling-edge enable flop
  logic              sel_byp;          // Bypass cell selected
  logic              sel_id;           // Identification selected
  logic              sel_bsr;          // Boundary register selected
  logic              ext_mode;         // External test in effect
  logic              hiz_mode;         // High-Z sample in effect
  logic              scan_out;         // Serial bit before retiming
  logic [`JDR_ID_W-1:0]  id_word;      // Fixed identification word
  logic [`JDR_BSR_W-1:0] bsr_cap;      // Capture image of the ring
  logic              wb_req;           // New Wishbone request
  logic [31:0]       stat_word;        // Status read image

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode on the test clock

  // Select lines from the active instruction
  always_comb
  begin
    sel_byp  = 1'b0;
    sel_id   = 1'b0;
    sel_bsr  = 1'b0;
    ext_mode = 1'b0;
    hiz_mode = 1'b0;
    case (t_q.ir_q)
      `JDR_IR_EXTEST:
      begin
        sel_bsr  = 1'b1;
        ext_mode = 1'b1;
      end
      `JDR_IR_IDCODE:
      begin
        sel_id = 1'b1;
      end
      `JDR_IR_SAMPZ:
      begin
        sel_bsr  = 1'b1;
        hiz_mode = 1'b1;
      end
      `JDR_IR_SAMPLE:
      begin
        // Sample only observes, nothing is steered
        sel_bsr = 1'b1;
      end
      `JDR_IR_BYPASS:
      begin
        sel_byp = 1'b1;
      end
      default:
      begin
        // Reserved codes fall back to the short path
        sel_byp = 1'b1;
      end
    endcase
  end

  // Fixed identification word
  assign id_word = {`JDR_ID_PART, `JDR_ID_MAKER, `JDR_ID_START};

  ////////////////////////////////////////////////////////////////////////
  // Capture image of the ring

  // One cell per pad; unconnected pads read zero
  genvar gi;
  generate
    for (gi = 0; gi < `JDR_PAD_N; gi = gi + 1)
    begin : g_cap
      localparam logic [`JDR_PAD_N-1:0] NC_M = `JDR_NC_MASK;
      // Unused pads keep their synced pin level
      assign bsr_cap[gi] = NC_M[gi] ? 1'b0 : t_q.pin_s2_q[gi];
    end
  endgenerate

  // Internal driver-control cell sits above the pads
  assign bsr_cap[`JDR_BSR_TOP] = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Test clock next state

  // Capture and shift of the three scan registers, update of the boundary register
  always_comb
  begin
    t_d = t_q;
    // Pads cross in through two flops before capture uses them
    t_d.pin_s1_q = pad_in;
    t_d.pin_s2_q = t_q.pin_s1_q;
    // New instruction only takes effect at Update-IR
    if (tap.update_ir)
    begin
      t_d.ir_q = tap.ir_value;
    end
    if (tap.capture_dr)
    begin
      if (sel_byp)
      begin
        t_d.byp_q = 1'b0;
      end
      if (sel_id)
      begin
        t_d.id_q = id_word;
      end
      if (sel_bsr)
      begin
        t_d.bsr_q = bsr_cap;
      end
    end
    else if (tap.shift_dr)
    begin
      // Only the selected register moves; tdi sampled on rising edge
      if (sel_byp)
      begin
        t_d.byp_q = tap.tdi;
      end
      if (sel_id)
      begin
        t_d.id_q = {tap.tdi, t_q.id_q[`JDR_ID_W-1:1]};
      end
      if (sel_bsr)
      begin
        t_d.bsr_q = {tap.tdi, t_q.bsr_q[`JDR_BSR_W-1:1]};
      end
    end
    else if (tap.update_dr && sel_bsr)
    begin
      // Pins see shifted data only from here on
      t_d.upd_q = t_q.bsr_q;
    end
  end

  // Test clock registers; tap reset restores identification
  always_ff @(posedge tck)
  begin
    if (!tap_rst_n)
    begin
      t_q.ir_q     <= `JDR_IR_IDCODE;
      t_q.pin_s1_q <= '0;
      t_q.pin_s2_q <= '0;
      t_q.byp_q    <= 1'b0;
      t_q.id_q     <= '0;
      t_q.bsr_q    <= '0;
      // Update latch clears so data drivers start released
      t_q.upd_q    <= '0;
    end
    else
    begin
      t_q <= t_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output

  // Path mux; only one register is ever selected
  always_comb
  begin
    scan_out = t_q.byp_q;
    if (sel_id)
    begin
      scan_out = t_q.id_q[0];
    end
    else if (sel_bsr)
    begin
      scan_out = t_q.bsr_q[0];
    end
  end

  // Falling edge retime gives the controller a half period of margin
  always_ff @(negedge tck)
  begin
    if (!tap_rst_n)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_q    <= scan_out;
      tdo_oe_q <= tap.shift_dr;
    end
  end

  assign tdo    = tdo_q;
  assign tdo_oe = tdo_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Pad drivers and termination

  // Scan data replaces the functional values under external test
  assign pad_out = ext_mode ? t_q.upd_q[`JDR_PAD_N-1:0] : c_q.func_q;

  // Per-pad enable; pins are asynchronous so mixing domains is harmless
  generate
    for (gi = 0; gi < `JDR_PAD_N; gi = gi + 1)
    begin : g_oe
      localparam logic [`JDR_PAD_N-1:0] OUT_M = `JDR_OUT_MASK;
      localparam logic [`JDR_PAD_N-1:0] DQ_M  = `JDR_DQ_MASK;
      always_comb
      begin
        if (!OUT_M[gi])
        begin
          // Input-only pads are never driven
          pad_oe[gi] = 1'b0;
        end
        else if (ext_mode)
        begin
          // Data drivers follow the internal cell, others always drive
          pad_oe[gi] = DQ_M[gi] ? t_q.upd_q[`JDR_BSR_TOP] : 1'b1;
        end
        else if (hiz_mode && DQ_M[gi])
        begin
          // High-Z sample floats the data drivers
          pad_oe[gi] = 1'b0;
        end
        else
        begin
          pad_oe[gi] = c_q.ctrl_q[`JDR_CTRL_DRV_BIT];
        end
      end
    end
  endgenerate

  // Termination follows software except in the two isolating modes
  assign odt_en = c_q.ctrl_q[`JDR_CTRL_ODT_BIT] & ~(ext_mode | hiz_mode);

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave on the system clock

  // A request is new until it has been acknowledged once
  assign wb_req = wb_cyc_i & wb_stb_i & ~c_q.ack_q;

  // Status image built from the settled instruction copy
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`JDR_IR_W-1:0] = c_q.ir_stat_q;
    stat_word[`JDR_STAT_EXT_BIT] = (c_q.ir_stat_q == `JDR_IR_EXTEST);
    stat_word[`JDR_STAT_HIZ_BIT] = (c_q.ir_stat_q == `JDR_IR_SAMPZ);
    stat_word[`JDR_STAT_ODT_BIT] = c_q.ctrl_q[`JDR_CTRL_ODT_BIT]
                                   & (c_q.ir_stat_q != `JDR_IR_EXTEST)
                                   & (c_q.ir_stat_q != `JDR_IR_SAMPZ);
  end

  // Register access, functional retiming and instruction crossing
  always_comb
  begin
    c_d = c_q;
    // Functional pad values come from flops
    c_d.func_q = func_out;
    // Instruction word crosses as a level; a copy is accepted only
    // once two samples agree, so a half-changed word is never shown
    c_d.ir_s1_q = t_q.ir_q;
    c_d.ir_s2_q = c_q.ir_s1_q;
    c_d.ir_s3_q = c_q.ir_s2_q;
    if (c_q.ir_s2_q == c_q.ir_s3_q)
    begin
      c_d.ir_stat_q = c_q.ir_s3_q;
    end
    // Acknowledge lasts one cycle
    c_d.ack_q  = wb_req;
    c_d.rdat_q = 32'h0000_0000;
    if (wb_req)
    begin
      case (wb_adr_i)
        `JDR_CTRL_ADDR:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            c_d.ctrl_q = wb_dat_i[`JDR_CTRL_W-1:0];
          end
          c_d.rdat_q[`JDR_CTRL_W-1:0] = c_q.ctrl_q;
        end
        `JDR_STAT_ADDR:
        begin
          // Read only; writes ignored
          c_d.rdat_q = stat_word;
        end
        `JDR_IDRD_ADDR:
        begin
          // Read only copy of the identification word
          c_d.rdat_q = id_word;
        end
        default:
        begin
          // Unmapped: acknowledged, reads zero
          c_d.rdat_q = 32'h0000_0000;
        end
      endcase
    end
  end

  // System clock registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      c_q.ctrl_q    <= `JDR_CTRL_RST;
      c_q.ack_q     <= 1'b0;
      c_q.rdat_q    <= 32'h0000_0000;
      c_q.func_q    <= '0;
      c_q.ir_s1_q   <= `JDR_IR_IDCODE;
      c_q.ir_s2_q   <= `JDR_IR_IDCODE;
      c_q.ir_s3_q   <= `JDR_IR_IDCODE;
      c_q.ir_stat_q <= `JDR_IR_IDCODE;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  assign wb_ack_o = c_q.ack_q;
  assign wb_dat_o = c_q.rdat_q;

endmodule

// File: rtl/jdr_params.svh
// Constants for the boundary-scan data registers: codes, widths, masks,
// register offsets, field positions and reset values.
// Assumes it is included by bare name from the package and the design.
`ifndef JDR_PARAMS_SVH
`define JDR_PARAMS_SVH

// Instruction field and its codes
`define JDR_IR_W          3
`define JDR_IR_EXTEST     3'h0
`define JDR_IR_IDCODE     3'h1
`define JDR_IR_SAMPZ      3'h2
`define JDR_IR_SAMPLE     3'h4
`define JDR_IR_BYPASS     3'h7

// Scan register widths
`define JDR_ID_W          32
`define JDR_BSR_W         129
`define JDR_PAD_N         128
`define JDR_BSR_TOP       128

// Identification word fields; part and maker values are arbitrary
`define JDR_ID_PART       20'h0a5c3
`define JDR_ID_MAKER      11'h2a5
`define JDR_ID_START      1'h1

// Pad role masks, bit i is boundary cell i+1
`define JDR_DQ_MASK       128'h0000_0000_0000_0000_0000_000f_ffff_ffff
`define JDR_OUT_MASK      128'h0000_0000_0000_0000_0000_007f_ffff_ffff
`define JDR_NC_MASK       128'hff00_0000_0000_0000_0000_0000_0000_0000

// Wishbone register offsets
`define JDR_WB_AW         4
`define JDR_CTRL_ADDR     4'h0
`define JDR_STAT_ADDR     4'h4
`define JDR_IDRD_ADDR     4'h8

// Control fields and reset value
`define JDR_CTRL_W        2
`define JDR_CTRL_ODT_BIT  0
`define JDR_CTRL_DRV_BIT  1
`define JDR_CTRL_RST      2'h1

// Status fields
`define JDR_STAT_EXT_BIT  3
`define JDR_STAT_HIZ_BIT  4
`define JDR_STAT_ODT_BIT  5

`endif

// File: rtl/jdr_pkg.sv
// Types shared by the boundary-scan data register block.
// Assumes the constants header is on the include path.
`include "jdr_params.svh"

package jdr_pkg;

  // Decoded TAP controller view, synchronous to the test clock
  typedef struct packed {
    logic                  capture_dr; // Capture-DR state
    logic                  shift_dr;   // Shift-DR state
    logic                  update_dr;  // Update-DR state
    logic                  update_ir;  // Update-IR state
    logic [`JDR_IR_W-1:0]  ir_value;   // Instruction shifted in
    logic                  tdi;        // Serial test input
  } jdr_tap_s;

  // State held on the test clock
  typedef struct packed {
    logic [`JDR_IR_W-1:0]  ir_q;       // Active instruction
    logic [`JDR_PAD_N-1:0] pin_s1_q;   // Pad sync, first stage
    logic [`JDR_PAD_N-1:0] pin_s2_q;   // Pad sync, second stage
    logic                  byp_q;      // Bypass cell
    logic [`JDR_ID_W-1:0]  id_q;       // Identification shifter
    logic [`JDR_BSR_W-1:0] bsr_q;      // Boundary shifter
    logic [`JDR_BSR_W-1:0] upd_q;      // Boundary update latch
  } jdr_tck_s;

  // State held on the system clock
  typedef struct packed {
    logic [`JDR_CTRL_W-1:0] ctrl_q;    // Control register
    logic                   ack_q;     // Wishbone acknowledge
    logic [31:0]            rdat_q;    // Read data
    logic [`JDR_PAD_N-1:0]  func_q;    // Functional pad values
    logic [`JDR_IR_W-1:0]   ir_s1_q;   // Instruction sync, first
    logic [`JDR_IR_W-1:0]   ir_s2_q;   // Instruction sync, second
    logic [`JDR_IR_W-1:0]   ir_s3_q;   // Previous second stage
    logic [`JDR_IR_W-1:0]   ir_stat_q; // Settled instruction copy
  } jdr_clk_s;

endpackage

// File: verification/jdr_data_regs_sva.sv
// Checker for the scan data registers, bound to the top module.
// Assumes tap holds steady around each rising tck.
`timescale 1ns/1ps
`include "jdr_params.svh"
module jdr_data_regs_sva (
  // System side
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  // Test side
  input wire logic                  tck,
  input wire logic                  tap_rst_n,
  input wire jdr_pkg::jdr_tap_s     tap,
  input wire logic                  tdo,
  input wire logic                  tdo_oe,
  input wire logic [`JDR_PAD_N-1:0] pad_out
);
  ////////////////////
  logic [2:0] ir_q; // Own copy of the instruction
  logic       byp;  // Bypass or reserved code

  // Track the instruction so rules can be keyed to it
  always_ff @(posedge tck)
  begin
    if (!tap_rst_n) ir_q <= `JDR_IR_IDCODE;
    else if (tap.update_ir) ir_q <= tap.ir_value;
  end
  assign byp = ir_q inside {3'h3, 3'h5, 3'h6, `JDR_IR_BYPASS};

  ////////////////////
  a_ack_pulse : assert property (@(posedge clock) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer : assert property (@(posedge clock) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_cause : assert property (@(posedge clock) disable iff (!rst_n)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack unasked");
  a_byp_zero : assert property (@(posedge tck) disable iff (!tap_rst_n)
    tap.capture_dr && byp |=> !tdo) else $error("bypass capture not 0");
  a_byp_path : assert property (@(posedge tck) disable iff (!tap_rst_n)
    tap.shift_dr && !tap.capture_dr && byp |=> tdo == $past(tap.tdi))
    else $error("bypass path wrong");
  a_id_start : assert property (@(posedge tck) disable iff (!tap_rst_n)
    tap.capture_dr && ir_q == `JDR_IR_IDCODE |=> tdo) else $error("no start bit");
  // Enable is raised on the falling edge inside the shift cycle, so it
  // matches the state level seen at the rising edge that closes it
  a_oe_shift : assert property (@(posedge tck) disable iff (!tap_rst_n)
    tap.shift_dr |-> tdo_oe) else $error("tdo not driven in shift");
  a_oe_idle : assert property (@(posedge tck) disable iff (!tap_rst_n)
    !tap.shift_dr |-> !tdo_oe) else $error("tdo driven outside shift");
  a_ext_hold : assert property (@(posedge tck) disable iff (!tap_rst_n)
    ir_q == `JDR_IR_EXTEST && tap.shift_dr |=> $stable(pad_out))
    else $error("pads moved while shifting");
endmodule

bind jdr_data_regs jdr_data_regs_sva u_jdr_data_regs_sva (.clock, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .tck, .tap_rst_n, .tap, .tdo, .tdo_oe, .pad_out);

// File: verification/jdr_tap_host.sv
// Behavioural TAP controller: tck runs only inside its tasks.
// Assumes the block decodes the instruction from update_ir itself.
`timescale 1ns/1ps
module jdr_tap_host (
  // Test clock and reset
  output logic              tck,
  output logic              tap_rst_n,
  // State view and serial return
  output jdr_pkg::jdr_tap_s tap,
  input  wire logic         tdo
);
  logic rst_nxt; // Reset level for the next cycle

  initial
  begin
    tck = 1'b0;
    tap_rst_n = 1'b0;
    tap = '0;
    rst_nxt = 1'b0;
  end

  ////////////////////
  // One period; tdo taken just before the rising edge
  task automatic step(input logic [7:0] nxt, output logic o);
    #3;
    o = tdo;
    tck = 1'b1;
    tap <= nxt;
    tap_rst_n <= rst_nxt;
    #3;
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic o;
    rst_nxt = 1'b0;
    repeat (3) step(8'h0, o);
    rst_nxt = 1'b1;
    repeat (2) step(8'h0, o);
  endtask

  // Update-IR with a code, then idle
  task automatic load_ir(input logic [2:0] code);
    logic o;
    step({4'h1, code, 1'b0}, o);
    repeat (2) step(8'h0, o);
  endtask

  // Capture, n shifts lsb first, update
  task automatic scan(input int n, input logic [128:0] din, output logic [128:0] dout);
    logic o;
    dout = '0;
    step(8'h80, o);
    for (int i = 0; i <= n; i++)
    begin
      step(i < n ? {7'h20, din[i]} : 8'h20, o);
      if (i > 0) dout[i-1] = o;
    end
    step(8'h0, o);
  endtask
endmodule

// File: verification/tb_jdr_data_regs.sv
// Self-checking bench for the scan data registers.
// Assumes the bound checker and the TAP controller model.
`timescale 1ns/1ps
`include "jdr_params.svh"
module tb_jdr_data_regs;
  localparam logic [127:0] PADS = {4{32'hc3a5_96f1}}; // Pin levels
  localparam logic [127:0] FUNC = {4{32'h5a0f_3c69}}; // Core values
  localparam logic [127:0] DRV  = {4{32'h9e37_1b4d}}; // Extest drive
  localparam logic [31:0]  IDW  = {`JDR_ID_PART, `JDR_ID_MAKER, `JDR_ID_START};
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]        wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o;
  logic              wb_ack_o, tck, tap_rst_n, tdo, tdo_oe, odt_en;
  jdr_pkg::jdr_tap_s tap;
  logic [127:0]      pad_in = PADS, func_out = FUNC, pad_out, pad_oe;
  int                fails = 0, n_checks = 0;
  logic [3:0]        sel_nxt = 4'hf; // Byte lanes for the next cycle

  always #20 clock = ~clock;

  jdr_data_regs u_jdr_data_regs (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tck, .tap_rst_n, .tap, .tdo, .tdo_oe,
    .pad_in, .func_out, .pad_out, .pad_oe, .odt_en);
  jdr_tap_host u_jdr_tap_host (.tck, .tap_rst_n, .tap, .tdo);

  ////////////////////
  task automatic chk(input logic [128:0] got, input logic [128:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; waits on ack, released after it
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel_nxt;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
  endtask

  ////////////////////
  task automatic t_regs();
    logic [31:0] r;
    wb(1'b0, `JDR_CTRL_ADDR, 32'h0, r);
    chk(129'(r), 129'(`JDR_CTRL_RST));
    wb(1'b1, `JDR_CTRL_ADDR, 32'h3, r);
    wb(1'b1, `JDR_STAT_ADDR, 32'hff, r);
    wb(1'b0, `JDR_CTRL_ADDR, 32'h0, r);
    chk(129'(r), 129'h3);
    // Control write without lane zero must leave the register alone
    sel_nxt = 4'he;
    wb(1'b1, `JDR_CTRL_ADDR, 32'h0, r);
    sel_nxt = 4'hf;
    wb(1'b0, `JDR_CTRL_ADDR, 32'h0, r);
    chk(129'(r), 129'h3);
    wb(1'b0, `JDR_STAT_ADDR, 32'h0, r);
    chk(129'(r), 129'h21);
    wb(1'b0, `JDR_IDRD_ADDR, 32'h0, r);
    chk(129'(r), 129'(IDW));
    wb(1'b0, 4'hc, 32'h0, r);
    chk(129'(r), 129'h0);
  endtask

  task automatic t_id();
    logic [128:0] d;
    u_jdr_tap_host.scan(64, 129'h8765_4321, d);
    chk(d, {65'h0, 32'h8765_4321, IDW});
  endtask

  task automatic t_byp();
    logic [128:0] d;
    logic [2:0]   codes [4] = '{`JDR_IR_BYPASS, 3'h3, 3'h5, 3'h6};
    foreach (codes[k])
    begin
      u_jdr_tap_host.load_ir(codes[k]);
      u_jdr_tap_host.scan(4, 129'hb, d);
      chk(d, 129'h6);
    end
  endtask

  task automatic t_bsr();
    logic [128:0] d;
    logic [31:0]  r;
    u_jdr_tap_host.load_ir(`JDR_IR_SAMPLE);
    settle();
    chk(129'(pad_out), 129'(FUNC));
    chk(129'({odt_en, pad_oe}), {1'b1, `JDR_OUT_MASK});
    u_jdr_tap_host.scan(129, 129'h0, d);
    chk(d, {1'b1, PADS & ~`JDR_NC_MASK});
    u_jdr_tap_host.load_ir(`JDR_IR_EXTEST);
    settle();
    wb(1'b0, `JDR_STAT_ADDR, 32'h0, r);
    chk(129'(r), 129'h8);
    u_jdr_tap_host.scan(129, {1'b1, DRV}, d);
    chk(d, {1'b1, PADS & ~`JDR_NC_MASK});
    settle();
    chk(129'(pad_out), 129'(DRV));
    chk(129'({odt_en, pad_oe}), 129'(`JDR_OUT_MASK));
    u_jdr_tap_host.scan(129, {1'b0, DRV}, d);
    settle();
    chk(129'(pad_oe), 129'(`JDR_OUT_MASK & ~`JDR_DQ_MASK));
    u_jdr_tap_host.load_ir(`JDR_IR_SAMPZ);
    settle();
    wb(1'b0, `JDR_STAT_ADDR, 32'h0, r);
    chk(129'(r), 129'h12);
    chk(129'({odt_en, pad_oe & `JDR_DQ_MASK}), 129'h0);
    u_jdr_tap_host.scan(129, 129'h0, d);
    chk(d, {1'b1, PADS & ~`JDR_NC_MASK});
  endtask

  ////////////////////
  task automatic close_out();
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    u_jdr_tap_host.reset_tap();
    settle();
    t_regs();
    t_id();
    t_byp();
    t_bsr();
    close_out();
  end

  // Hang guard, well past the expected run
  initial
  begin
    #400000;
    fails++;
    close_out();
  end
endmodule
